// *** src/ext_bus_pkg.sv ***
// constants and types for the external memory bus pin block
package ext_bus_pkg;
    // clock and machine cycle
    localparam int         CLK_MHZ   = 100;
    localparam int         MC_OSC    = 12;
    localparam int         RST_MC    = 2;
    localparam int         RST_CYC   = RST_MC * MC_OSC;
    localparam int         RST_CW    = 5;
    localparam logic [4:0] RST_LAST  = 5'(RST_CYC - 1);
    localparam logic [3:0] PH_LAST   = 4'(MC_OSC - 1);
    // phase windows inside one machine cycle
    localparam logic [3:0] PH_ALE1_LO = 4'h0;
    localparam logic [3:0] PH_ALE1_HI = 4'h1;
    localparam logic [3:0] PH_ALE2_LO = 4'h6;
    localparam logic [3:0] PH_ALE2_HI = 4'h7;
    localparam logic [3:0] PH_AD1_HI  = 4'h2;
    localparam logic [3:0] PH_AD2_HI  = 4'h8;
    localparam logic [3:0] PH_PS1_LO  = 4'h3;
    localparam logic [3:0] PH_PS1_HI  = 4'h5;
    localparam logic [3:0] PH_PS2_LO  = 4'h9;
    localparam logic [3:0] PH_PS2_HI  = 4'hB;
    localparam logic [3:0] PH_STB_LO  = 4'h3;
    localparam logic [3:0] PH_STB_HI  = 4'hA;
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_LOW    = 10'h080;
    localparam logic [9:0] IDX_DPL    = 10'h082;
    localparam logic [9:0] IDX_DPH    = 10'h083;
    localparam logic [9:0] IDX_ALEC   = 10'h08E;
    localparam logic [9:0] IDX_GEN    = 10'h090;
    localparam logic [9:0] IDX_HIGH   = 10'h0A0;
    localparam logic [9:0] IDX_AUX    = 10'h0B0;
    localparam logic [9:0] IDX_IND    = 10'h100;
    localparam logic [9:0] IDX_CMD    = 10'h101;
    localparam logic [9:0] IDX_WDAT   = 10'h102;
    localparam logic [9:0] IDX_RDAT   = 10'h103;
    localparam logic [9:0] IDX_STAT   = 10'h104;
    localparam logic [9:0] IDX_PIN0   = 10'h105;
    localparam logic [9:0] IDX_PIN1   = 10'h106;
    localparam logic [9:0] IDX_PIN2   = 10'h107;
    localparam logic [9:0] IDX_PIN3   = 10'h108;
    localparam logic [9:0] IDX_FETCH  = 10'h109;
    // reset values and fields
    localparam logic [7:0] PORT_RST   = 8'hFF;
    localparam logic [7:0] ZERO_RST   = 8'h00;
    localparam logic [34:0] PIN_IDLE  = 35'h3FFFFFFFF;
    localparam int         ALE_DIS_B  = 0;
    localparam int         CMD_WIDE_DATA_POINTER_B = 2;
    localparam int         CMD_GO_B   = 7;
    localparam int         AUX_WR_B   = 6;
    localparam int         AUX_RD_B   = 7;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;

    typedef enum logic [1:0] {ACC_RD, ACC_WR, ACC_CODE} acc_kind_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_PEND, SEQ_ACC} seq_t;
    typedef struct packed {
        acc_kind_t kind;
        logic      use_wide_data_pointer;
    } acc_cmd_t;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } port_drv_t;
endpackage : ext_bus_pkg

// *** src/ext_bus_pins.sv ***
// external memory bus pin control with register access over axi4-lite
// Notes on behaviour
// (RULE_01) reset pin high two machine cycles resets
// (RULE_02) latch strobe runs at one sixth clock
// (RULE_03) one latch strobe dropped per data access
// (RULE_04) disable bit limits strobe to access cycles
// (RULE_05) external execution overrides the disable bit
// (RULE_06) low port multiplexes address then data
// (RULE_07) bus mode drives ones, else open drain
// (RULE_08) high port drives high address byte strongly
// (RULE_09) eight-bit indirect access shows high latch
// (RULE_10) program strobe twice per machine cycle externally
// (RULE_11) data access drops two program strobes
// (RULE_12) fetch select low means external code
// (RULE_13) locked part latches fetch select at reset
// (RULE_14) aux bits six, seven are write, read
// (RULE_15) latch one releases pin to pullup
// (RULE_16) machine cycle equals twelve clock periods
// (RULE_17) external latch captures on strobe falling edge
// (RULE_18) strobes active low, idle high; the address latch strobe here pulses high and idles low
`timescale 1ns/100ps
`default_nettype none
module ext_bus_pins (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [11:0]            awaddr,
    input  wire logic                   awvalid,
    output var  logic                   awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output var  logic                   wready,
    output var  logic [1:0]             bresp,
    output var  logic                   bvalid,
    input  wire logic                   bready,
    input  wire logic [11:0]            araddr,
    input  wire logic                   arvalid,
    output var  logic                   arready,
    output var  logic [31:0]            rdata,
    output var  logic [1:0]             rresp,
    output var  logic                   rvalid,
    input  wire logic                   rready,
    input  wire logic                   reset_pin,
    input  wire logic                   external_fetch_select_n,
    input  wire logic                   lock_bit1_programmed,
    input  wire logic [7:0]             low_port_in,
    input  wire logic [7:0]             general_port_in,
    input  wire logic [7:0]             high_port_in,
    input  wire logic [7:0]             aux_port_in,
    output var  ext_bus_pkg::port_drv_t low_port_drv,
    output var  ext_bus_pkg::port_drv_t general_port_drv,
    output var  ext_bus_pkg::port_drv_t high_port_drv,
    output var  ext_bus_pkg::port_drv_t aux_port_drv,
    output var  logic                   address_latch_strobe,
    output var  logic                   ale_weak_pullup,
    output var  logic                   program_read_strobe_n
);
    function automatic logic inr(input logic [3:0] p, input logic [3:0] lo, input logic [3:0] hi);
        inr = (p >= lo) && (p <= hi);
    endfunction : inr

    // pin synchronisers: three stages, change taken when stages two and three agree
    logic [34:0] s1_r, s2_r, s3_r, filt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {s1_r, s2_r, s3_r, filt_r} <= {4{ext_bus_pkg::PIN_IDLE}};
        end else begin
            s1_r   <= {lock_bit1_programmed, external_fetch_select_n, reset_pin,
                       aux_port_in, high_port_in, general_port_in, low_port_in};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
        end
    end
    logic [7:0] low_f, gen_f, high_f, aux_f;
    logic       rst_f, ea_n_f, lock_f;
    assign {lock_f, ea_n_f, rst_f, aux_f, high_f, gen_f, low_f} = filt_r;

    // reset pin must stay high a full two machine cycles; glitches restart the count
    logic [4:0] rst_cnt_r;
    logic       hold_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_cnt_r <= '0;
            hold_r    <= 1'b1;
        end else if (!rst_f) begin
            rst_cnt_r <= '0;
            hold_r    <= 1'b0;
        end else if (rst_cnt_r == ext_bus_pkg::RST_LAST) begin
            hold_r    <= 1'b1; // see RULE_01 see RULE_16
        end else begin
            rst_cnt_r <= rst_cnt_r + 5'h01;
        end
    end
    logic dev_rst;
    assign dev_rst = !aresetn || hold_r;

    // fetch select strap: latched during reset when the lock bit is set
    logic ea_lat_r, ext_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ea_lat_r <= 1'b1;
            ext_r    <= 1'b0;
        end else begin
            if (hold_r)
                ea_lat_r <= ea_n_f; // see RULE_13
            ext_r <= lock_f ? !ea_lat_r : !ea_n_f; // see RULE_12
        end
    end

    // write channel: address and data taken in either order
    logic [11:0] aw_a_r;
    logic [7:0]  wd_r;
    logic        ws0_r, aw_full_r, w_full_r, aw_fire, w_fire, wr_fire;
    logic        aw_full_nxt, w_full_nxt;
    assign aw_fire     = awvalid && awready;
    assign w_fire      = wvalid && wready;
    assign wr_fire     = aw_full_r && w_full_r && !bvalid;
    assign aw_full_nxt = (aw_full_r || aw_fire) && !wr_fire;
    assign w_full_nxt  = (w_full_r || w_fire) && !wr_fire;
    logic [9:0] wi;
    assign wi = aw_a_r[11:2];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= ext_bus_pkg::RESP_OKAY;
            aw_a_r    <= '0;
            wd_r      <= '0;
            ws0_r     <= 1'b0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            awready   <= !aw_full_nxt;
            wready    <= !w_full_nxt;
            if (aw_fire)
                aw_a_r <= awaddr;
            if (w_fire) begin
                wd_r  <= wdata[7:0];
                ws0_r <= wstrb[0];
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp  <= reg_hit(wi) ? ext_bus_pkg::RESP_OKAY : ext_bus_pkg::RESP_SLV;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    function automatic logic reg_hit(input logic [9:0] i);
        reg_hit = (i == ext_bus_pkg::IDX_LOW) || (i == ext_bus_pkg::IDX_DPL) ||
                  (i == ext_bus_pkg::IDX_DPH) || (i == ext_bus_pkg::IDX_ALEC) ||
                  (i == ext_bus_pkg::IDX_GEN) || (i == ext_bus_pkg::IDX_HIGH) ||
                  (i == ext_bus_pkg::IDX_AUX) ||
                  ((i >= ext_bus_pkg::IDX_IND) && (i <= ext_bus_pkg::IDX_FETCH));
    endfunction : reg_hit

    // software registers and access sequencer state
    logic [7:0] low_l_r, dpl_r, dph_r, gen_l_r, high_l_r, aux_l_r, ind_r, wdat_r, rdat_r, fetch_r;
    logic       ale_dis_r, done_r, we;
    logic [15:0] pc_r;
    logic [3:0]  ph_r;
    ext_bus_pkg::seq_t     seq_r;
    ext_bus_pkg::acc_cmd_t cmd_r;
    logic go_wr, acc, acc_end;
    assign we      = wr_fire && ws0_r;
    assign go_wr   = we && (wi == ext_bus_pkg::IDX_CMD) && wd_r[ext_bus_pkg::CMD_GO_B] &&
                     (wd_r[1:0] != 2'h3) && (seq_r == ext_bus_pkg::SEQ_IDLE);
    assign acc     = (seq_r == ext_bus_pkg::SEQ_ACC);
    assign acc_end = acc && (ph_r == ext_bus_pkg::PH_LAST);
    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            low_l_r   <= ext_bus_pkg::PORT_RST;
            gen_l_r   <= ext_bus_pkg::PORT_RST;
            high_l_r  <= ext_bus_pkg::PORT_RST;
            aux_l_r   <= ext_bus_pkg::PORT_RST;
            dpl_r     <= ext_bus_pkg::ZERO_RST;
            dph_r     <= ext_bus_pkg::ZERO_RST;
            ind_r     <= ext_bus_pkg::ZERO_RST;
            wdat_r    <= ext_bus_pkg::ZERO_RST;
            ale_dis_r <= 1'b0;
        end else if (we) begin
            case (wi)
                ext_bus_pkg::IDX_LOW:  low_l_r   <= wd_r;
                ext_bus_pkg::IDX_DPL:  dpl_r     <= wd_r;
                ext_bus_pkg::IDX_DPH:  dph_r     <= wd_r;
                ext_bus_pkg::IDX_ALEC: ale_dis_r <= wd_r[ext_bus_pkg::ALE_DIS_B];
                ext_bus_pkg::IDX_GEN:  gen_l_r   <= wd_r;
                ext_bus_pkg::IDX_HIGH: high_l_r  <= wd_r;
                ext_bus_pkg::IDX_AUX:  aux_l_r   <= wd_r;
                ext_bus_pkg::IDX_IND:  ind_r     <= wd_r;
                ext_bus_pkg::IDX_WDAT: wdat_r    <= wd_r;
                default: ;
            endcase
        end
    end

    // machine cycle phase and one-cycle external access sequencing
    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            ph_r   <= '0;
            seq_r  <= ext_bus_pkg::SEQ_IDLE;
            cmd_r  <= '{kind: ext_bus_pkg::ACC_RD, use_wide_data_pointer: 1'b0};
            done_r <= 1'b0;
        end else begin
            ph_r <= (ph_r == ext_bus_pkg::PH_LAST) ? 4'h0 : ph_r + 4'h1; // see RULE_16
            case (seq_r)
                ext_bus_pkg::SEQ_IDLE: if (go_wr) begin
                    seq_r <= ext_bus_pkg::SEQ_PEND;
                    cmd_r <= '{kind: ext_bus_pkg::acc_kind_t'(wd_r[1:0]),
                               use_wide_data_pointer: wd_r[ext_bus_pkg::CMD_WIDE_DATA_POINTER_B]};
                end
                ext_bus_pkg::SEQ_PEND: if (ph_r == ext_bus_pkg::PH_LAST)
                    seq_r <= ext_bus_pkg::SEQ_ACC;
                ext_bus_pkg::SEQ_ACC: if (acc_end)
                    seq_r <= ext_bus_pkg::SEQ_IDLE;
                default: seq_r <= ext_bus_pkg::SEQ_IDLE;
            endcase
            // completion flag: setting beats a clearing command write
            if (acc_end)
                done_r <= 1'b1;
            else if (go_wr)
                done_r <= 1'b0;
        end
    end

    // fetch counter and captured bytes; capture at the last low phase of each strobe
    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            pc_r    <= '0;
            fetch_r <= ext_bus_pkg::ZERO_RST;
            rdat_r  <= ext_bus_pkg::ZERO_RST;
        end else if (acc) begin
            if (cmd_r.kind == ext_bus_pkg::ACC_CODE && ph_r == ext_bus_pkg::PH_PS1_HI)
                rdat_r <= low_f;
            else if (cmd_r.kind == ext_bus_pkg::ACC_RD && ph_r == ext_bus_pkg::PH_STB_HI)
                rdat_r <= low_f;
        end else if (ext_r && (ph_r == ext_bus_pkg::PH_PS1_HI || ph_r == ext_bus_pkg::PH_PS2_HI)) begin
            fetch_r <= low_f;
            pc_r    <= pc_r + 16'h0001;
        end
    end

    // read channel: answer in the cycle after the address is taken
    logic [7:0] rbyte;
    logic [9:0] ri;
    assign ri = araddr[11:2];
    always_comb begin
        case (ri)
            ext_bus_pkg::IDX_LOW:   rbyte = low_l_r;
            ext_bus_pkg::IDX_DPL:   rbyte = dpl_r;
            ext_bus_pkg::IDX_DPH:   rbyte = dph_r;
            ext_bus_pkg::IDX_ALEC:  rbyte = {7'h00, ale_dis_r};
            ext_bus_pkg::IDX_GEN:   rbyte = gen_l_r;
            ext_bus_pkg::IDX_HIGH:  rbyte = high_l_r;
            ext_bus_pkg::IDX_AUX:   rbyte = aux_l_r;
            ext_bus_pkg::IDX_IND:   rbyte = ind_r;
            ext_bus_pkg::IDX_CMD:   rbyte = {5'h00, cmd_r.use_wide_data_pointer, cmd_r.kind};
            ext_bus_pkg::IDX_WDAT:  rbyte = wdat_r;
            ext_bus_pkg::IDX_RDAT:  rbyte = rdat_r;
            ext_bus_pkg::IDX_STAT:  rbyte = {4'h0, hold_r, ext_r, done_r, seq_r != ext_bus_pkg::SEQ_IDLE};
            ext_bus_pkg::IDX_PIN0:  rbyte = low_f;
            ext_bus_pkg::IDX_PIN1:  rbyte = gen_f;
            ext_bus_pkg::IDX_PIN2:  rbyte = high_f;
            ext_bus_pkg::IDX_PIN3:  rbyte = aux_f;
            ext_bus_pkg::IDX_FETCH: rbyte = fetch_r;
            default:                rbyte = 8'h00;
        endcase
    end
    logic ar_fire, rvalid_nxt;
    assign ar_fire    = arvalid && arready;
    assign rvalid_nxt = (rvalid && !rready) || ar_fire;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= ext_bus_pkg::RESP_OKAY;
        end else begin
            arready <= !rvalid_nxt;
            rvalid  <= rvalid_nxt;
            if (ar_fire) begin
                rdata <= {24'h000000, rbyte};
                rresp <= reg_hit(ri) ? ext_bus_pkg::RESP_OKAY : ext_bus_pkg::RESP_SLV;
            end
        end
    end

    // pin drive decode from phase; all pins registered one cycle later
    logic [15:0] ad;
    logic        ale_n, ale_off, program_read_strobe_lo, stb_lo, ad_ph, hi_strong;
    ext_bus_pkg::port_drv_t lo_nxt, hi_nxt, aux_nxt;
    always_comb begin
        ad        = pc_r;
        ale_n     = inr(ph_r, ext_bus_pkg::PH_ALE1_LO, ext_bus_pkg::PH_ALE1_HI) ||
                    inr(ph_r, ext_bus_pkg::PH_ALE2_LO, ext_bus_pkg::PH_ALE2_HI); // see RULE_02
        ale_off   = ale_dis_r && !ext_r && !acc; // see RULE_04 see RULE_05
        program_read_strobe_lo   = ext_r && (inr(ph_r, ext_bus_pkg::PH_PS1_LO, ext_bus_pkg::PH_PS1_HI) ||
                    inr(ph_r, ext_bus_pkg::PH_PS2_LO, ext_bus_pkg::PH_PS2_HI)); // see RULE_10
        ad_ph     = ext_r && (inr(ph_r, ext_bus_pkg::PH_ALE1_LO, ext_bus_pkg::PH_AD1_HI) ||
                    inr(ph_r, ext_bus_pkg::PH_ALE2_LO, ext_bus_pkg::PH_AD2_HI));
        stb_lo    = 1'b0;
        hi_strong = ext_r; // see RULE_08
        // ordinary port: zeros driven, ones released to the pullup
        lo_nxt    = '{out: low_l_r, oe_n: low_l_r}; // see RULE_15
        if (acc) begin
            ale_n   = inr(ph_r, ext_bus_pkg::PH_ALE1_LO, ext_bus_pkg::PH_ALE1_HI) ||
                      (cmd_r.kind == ext_bus_pkg::ACC_CODE &&
                       inr(ph_r, ext_bus_pkg::PH_ALE2_LO, ext_bus_pkg::PH_ALE2_HI)); // see RULE_03
            program_read_strobe_lo = cmd_r.kind == ext_bus_pkg::ACC_CODE &&
                      inr(ph_r, ext_bus_pkg::PH_PS1_LO, ext_bus_pkg::PH_PS1_HI); // see RULE_11
            stb_lo  = cmd_r.kind != ext_bus_pkg::ACC_CODE &&
                      inr(ph_r, ext_bus_pkg::PH_STB_LO, ext_bus_pkg::PH_STB_HI);
            ad_ph   = ph_r <= ext_bus_pkg::PH_AD1_HI;
            hi_strong = cmd_r.use_wide_data_pointer || cmd_r.kind == ext_bus_pkg::ACC_CODE; // see RULE_09
            ad      = hi_strong ? {dph_r, dpl_r} : {high_l_r, ind_r};
            if (!ad_ph)
                lo_nxt = (cmd_r.kind == ext_bus_pkg::ACC_WR) ? '{out: wdat_r, oe_n: 8'h00}
                                                             : '{out: 8'hFF, oe_n: 8'hFF}; // see RULE_06
        end else if (ext_r && !ad_ph) begin
            lo_nxt = '{out: 8'hFF, oe_n: 8'hFF};
        end
        if (ad_ph)
            lo_nxt = '{out: ad[7:0], oe_n: 8'h00}; // see RULE_06 see RULE_07
        hi_nxt  = hi_strong ? '{out: ad[15:8], oe_n: 8'h00} : '{out: high_l_r, oe_n: high_l_r};
        aux_nxt = '{out: aux_l_r, oe_n: aux_l_r};
        if (stb_lo && cmd_r.kind == ext_bus_pkg::ACC_WR) begin
            aux_nxt.out[ext_bus_pkg::AUX_WR_B]  = 1'b0; // see RULE_14
            aux_nxt.oe_n[ext_bus_pkg::AUX_WR_B] = 1'b0;
        end
        if (stb_lo && cmd_r.kind == ext_bus_pkg::ACC_RD) begin
            aux_nxt.out[ext_bus_pkg::AUX_RD_B]  = 1'b0; // see RULE_14
            aux_nxt.oe_n[ext_bus_pkg::AUX_RD_B] = 1'b0;
        end
    end

    // output flops; during device reset pins float and strobes idle
    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            low_port_drv          <= '{out: 8'hFF, oe_n: 8'hFF};
            general_port_drv      <= '{out: 8'hFF, oe_n: 8'hFF};
            high_port_drv         <= '{out: 8'hFF, oe_n: 8'hFF};
            aux_port_drv          <= '{out: 8'hFF, oe_n: 8'hFF};
            address_latch_strobe  <= 1'b0;
            ale_weak_pullup       <= 1'b0;
            program_read_strobe_n <= 1'b1;
        end else begin
            low_port_drv          <= lo_nxt;
            general_port_drv      <= '{out: gen_l_r, oe_n: gen_l_r};
            high_port_drv         <= hi_nxt;
            aux_port_drv          <= aux_nxt;
            address_latch_strobe  <= ale_off || ale_n;
            ale_weak_pullup       <= ale_off;
            program_read_strobe_n <= !program_read_strobe_lo; // see RULE_18
        end
    end

    property p_rst_len;
        @(posedge aclk) disable iff (!aresetn)
        $rose(hold_r) |-> $past(rst_cnt_r) == ext_bus_pkg::RST_LAST && $past(rst_f);
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset taken too early"); // see RULE_01
    property p_ale_rate;
        @(posedge aclk) disable iff (dev_rst)
        (ph_r == 4'h3 && !acc && !ale_off && seq_r != ext_bus_pkg::SEQ_PEND) |->
            (!address_latch_strobe || ale_weak_pullup)[*4] ##1 address_latch_strobe[*2];
    endproperty
    a_ale_rate: assert property (p_ale_rate) else $error("latch strobe not at one sixth rate"); // see RULE_02
    property p_ale_skip;
        @(posedge aclk) disable iff (dev_rst)
        (acc && cmd_r.kind != ext_bus_pkg::ACC_CODE && ph_r == 4'h8) |-> !address_latch_strobe && $past(!address_latch_strobe);
    endproperty
    a_ale_skip: assert property (p_ale_skip) else $error("latch strobe not dropped"); // see RULE_03
    property p_ale_off;
        @(posedge aclk) disable iff (dev_rst)
        (ale_dis_r && !ext_r && $past(ale_off) && !$past(acc)) |-> address_latch_strobe && ale_weak_pullup;
    endproperty
    a_ale_off: assert property (p_ale_off) else $error("disabled latch strobe not weak high"); // see RULE_04
    property p_program_read_strobe_two;
        @(posedge aclk) disable iff (dev_rst)
        (ext_r && !acc && ph_r == ext_bus_pkg::PH_PS1_LO) |=> !program_read_strobe_n[*3] ##1 program_read_strobe_n[*3] ##1 !program_read_strobe_n;
    endproperty
    a_program_read_strobe_two: assert property (p_program_read_strobe_two) else $error("program strobe not twice per cycle"); // see RULE_10
    property p_program_read_strobe_skip;
        @(posedge aclk) disable iff (dev_rst)
        (acc && cmd_r.kind != ext_bus_pkg::ACC_CODE && (ph_r == 4'h4 || ph_r == 4'hA)) |-> program_read_strobe_n;
    endproperty
    a_program_read_strobe_skip: assert property (p_program_read_strobe_skip) else $error("program strobe during data access"); // see RULE_11
    property p_rd_stb;
        @(posedge aclk) disable iff (dev_rst)
        (acc && cmd_r.kind == ext_bus_pkg::ACC_RD && ph_r == ext_bus_pkg::PH_STB_LO) |=> !aux_port_drv.out[7][*8];
    endproperty
    a_rd_stb: assert property (p_rd_stb) else $error("read strobe not low eight cycles"); // see RULE_14
    property p_bus_ones;
        @(posedge aclk) disable iff (dev_rst)
        (acc && ph_r == 4'h0) |=> low_port_drv.oe_n == 8'h00 && low_port_drv.out == $past(ad[7:0]);
    endproperty
    a_bus_ones: assert property (p_bus_ones) else $error("address byte not driven"); // see RULE_07
    property p_ea_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!hold_r && $past(!hold_r)) |-> $stable(ea_lat_r);
    endproperty
    a_ea_hold: assert property (p_ea_hold) else $error("strap changed after reset"); // see RULE_13
endmodule : ext_bus_pins
`default_nettype wire

// *** testbench/mem_model.sv ***
// external address latch and memory seen from the low port
`timescale 1ns/100ps
`default_nettype none
module mem_model (
    input  wire logic                   aclk,
    input  wire ext_bus_pkg::port_drv_t low_port_drv,
    input  wire ext_bus_pkg::port_drv_t aux_port_drv,
    input  wire logic                   address_latch_strobe,
    output var  logic [7:0]             low_port_in,
    output var  logic [7:0]             wr_byte_r
);
    logic [7:0] addr_r;
    logic [7:0] flt_r;
    logic       ale_q;
    logic       rd_on;
    // latch address on strobe fall, take write data while write strobe low
    always @(posedge aclk) begin
        ale_q <= address_latch_strobe;
        flt_r <= ~low_port_in; // released lines never repeat a stale value
        if (ale_q && !address_latch_strobe) addr_r <= low_port_drv.out;
        if (!aux_port_drv.oe_n[6] && !aux_port_drv.out[6]) wr_byte_r <= low_port_drv.out;
    end
    // memory answers the complement of the latched address during read strobe
    assign rd_on = !aux_port_drv.oe_n[7] && !aux_port_drv.out[7];
    assign low_port_in = (~low_port_drv.oe_n & low_port_drv.out) | (low_port_drv.oe_n & (rd_on ? ~addr_r : flt_r));
endmodule : mem_model
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the external memory bus pin block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic reset_pin = 1'h1, ea_n = 1'h1, clr = 1'h0, ale_q, awready, wready, bvalid, arready, rvalid;
    logic address_latch_strobe, ale_weak_pullup, program_read_strobe_n;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp;
    logic [7:0]  low_port_in, general_port_in, high_port_in, aux_port_in, wr_byte, hi_seen;
    ext_bus_pkg::port_drv_t low_port_drv, general_port_drv, high_port_drv, aux_port_drv;
    int failures = 0, n_tests = 0, cyc = 0, win = 0, n_ale, n_rd, n_wr, n_ps;
    // pulled-up ports resolve to the driven level or one
    assign general_port_in = general_port_drv.out | general_port_drv.oe_n;
    assign high_port_in = high_port_drv.out | high_port_drv.oe_n;
    assign aux_port_in = aux_port_drv.out | aux_port_drv.oe_n;
    ext_bus_pins u_ext_bus_pins (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .reset_pin,
        .external_fetch_select_n(ea_n), .lock_bit1_programmed(1'h0), .low_port_in, .general_port_in, .high_port_in,
        .aux_port_in, .low_port_drv, .general_port_drv, .high_port_drv, .aux_port_drv, .address_latch_strobe,
        .ale_weak_pullup, .program_read_strobe_n);
    mem_model u_mem_model (.aclk, .low_port_drv, .aux_port_drv, .address_latch_strobe, .low_port_in, .wr_byte_r(wr_byte));
    always #5 aclk = ~aclk;
    // hang guard, run needs well under a thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin failures++; close_out(); end
    end
    // pin monitor over a 48-cycle window, four whole machine cycles
    always @(posedge aclk) begin
        ale_q <= address_latch_strobe;
        win <= clr ? 48 : (win > 0 ? win - 1 : 0);
        n_ale <= clr ? 0 : n_ale + int'(win > 0 && address_latch_strobe && !ale_q);
        n_rd <= clr ? 0 : n_rd + int'(win > 0 && !aux_port_drv.out[7] && !aux_port_drv.oe_n[7]);
        n_wr <= clr ? 0 : n_wr + int'(win > 0 && !aux_port_drv.out[6] && !aux_port_drv.oe_n[6]);
        n_ps <= clr ? 0 : n_ps + int'(win > 0 && !program_read_strobe_n);
        if (!aux_port_drv.out[6] && !aux_port_drv.oe_n[6] && high_port_drv.oe_n === 8'h00) hi_seen <= high_port_drv.out;
    end
    task automatic close_out();
        $display("mismatches %0d of %0d comparisons", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin failures++; $display("[ERR] %0t got %h expected %h", $time, g, e); end
    endtask : chk
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= {i, 2'h0}; wdata <= {24'h0, d}; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        chk(bresp, ext_bus_pkg::RESP_OKAY);
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= {i, 2'h0}; arvalid <= 1'h1; rready <= 1'h1;
        do begin @(posedge aclk); if (arready) arvalid <= 1'h0; end while (!rvalid);
        chk(rresp, er);
        chk(rdata, e);
        rready <= 1'h0;
    endtask : rd
    // open a window, optionally start an access, judge strobe counts
    task automatic t_win(input logic [7:0] cmd, input int e_ale, input int e_rd, input int e_wr, input int e_ps);
        clr <= 1'h1;
        @(posedge aclk);
        clr <= 1'h0;
        if (cmd[7]) wr(ext_bus_pkg::IDX_CMD, cmd);
        repeat (60) @(posedge aclk);
        chk(n_ale, e_ale);
        chk(n_rd, e_rd);
        chk(n_wr, e_wr);
        chk(n_ps, e_ps);
    endtask : t_win
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (30) @(posedge aclk);
        reset_pin <= 1'h0; // held well past two machine cycles
        repeat (10) @(posedge aclk);
        rd(ext_bus_pkg::IDX_LOW, 32'hFF, ext_bus_pkg::RESP_OKAY);
        rd(10'h3FF, 32'h0, ext_bus_pkg::RESP_SLV);
        wr(ext_bus_pkg::IDX_GEN, 8'hF0);
        @(posedge aclk);
        chk(general_port_drv, 16'hF0F0);
        t_win(8'h00, 8, 0, 0, 0);
        wr(ext_bus_pkg::IDX_IND, 8'h5A);
        t_win(8'h80, 7, 8, 0, 0);
        rd(ext_bus_pkg::IDX_RDAT, 32'hA5, ext_bus_pkg::RESP_OKAY);
        wr(ext_bus_pkg::IDX_DPH, 8'h12);
        wr(ext_bus_pkg::IDX_WDAT, 8'h3C);
        t_win(8'h85, 7, 0, 8, 0);
        chk({hi_seen, wr_byte}, 16'h123C);
        wr(ext_bus_pkg::IDX_ALEC, 8'h01);
        t_win(8'h80, 1, 8, 0, 0);
        chk(ale_weak_pullup, 1'h1);
        ea_n <= 1'h0;
        repeat (8) @(posedge aclk);
        t_win(8'h00, 8, 0, 0, 24);
        @(posedge aclk);
        reset_pin <= 1'h1;
        repeat (28) @(posedge aclk);
        reset_pin <= 1'h0;
        repeat (10) @(posedge aclk);
        rd(ext_bus_pkg::IDX_GEN, 32'hFF, ext_bus_pkg::RESP_OKAY);
        close_out();
    end
endmodule : testbench
`default_nettype wire
